/* logic/fqbi_pkg.sv */
//==============================================================================
// Notes on behaviour
// - The page capability byte holds n for a read page of 2**n bytes, zero meaning no page buffer.
// - The page capability byte reads 05 on the plain interface and 00 on the multiplexed one.
// - The burst field count reads 03, where zero would mean no burst support.
// - Each burst field holds a code n in bits 2:0 for bursts of 2**(n+1) words, bits 7:3 reserved zero.
// - Code 07 means continuous linear bursting to the end of the burstable space.
// - The three burst fields read 02, 03 and 07 in that order.
// - The partition region count gives the region number, zero meaning a single partition.
// - The OTP tail reads user group count low 10, high 00, and bytes per group code 04.
package fqbi_pkg;

  //============================================================================
  // Register word indices; byte address is four times the index.
  localparam logic [11:0] FQBI_IDX_GRP_LO   = 12'h124;
  localparam logic [11:0] FQBI_IDX_GRP_HI   = 12'h125;
  localparam logic [11:0] FQBI_IDX_BYTES    = 12'h126;
  localparam logic [11:0] FQBI_IDX_PAGE     = 12'h127;
  localparam logic [11:0] FQBI_IDX_BCOUNT   = 12'h128;
  localparam logic [11:0] FQBI_IDX_BCFG1    = 12'h129;
  localparam logic [11:0] FQBI_IDX_BCFG2    = 12'h12a;
  localparam logic [11:0] FQBI_IDX_BCFG3    = 12'h12b;
  localparam logic [11:0] FQBI_IDX_PREGIONS = 12'h12c;

  //============================================================================
  // Fixed byte values of the table.
  localparam logic [7:0] FQBI_VAL_GRP_LO    = 8'h10;
  localparam logic [7:0] FQBI_VAL_GRP_HI    = 8'h00;
  localparam logic [7:0] FQBI_VAL_BYTES     = 8'h04;
  localparam logic [7:0] FQBI_VAL_PAGE_NMUX = 8'h05;
  localparam logic [7:0] FQBI_VAL_PAGE_MUX  = 8'h00;
  localparam logic [7:0] FQBI_VAL_BCOUNT    = 8'h03;
  localparam logic [2:0] FQBI_CODE_8W       = 3'h2;
  localparam logic [2:0] FQBI_CODE_16W      = 3'h3;
  localparam logic [2:0] FQBI_CODE_CONT     = 3'h7;
  localparam logic [7:0] FQBI_VAL_PREGIONS  = 8'h00;

  //============================================================================
  // Bus answer carried back to the master.
  typedef struct packed {
    logic [31:0] rdata;
    logic        slverr;
  } fqbi_resp_s;

endpackage

/* logic/fqbi_query_table.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module fqbi_query_table
  import fqbi_pkg::*;
#(
  parameter logic [7:0] REGION_COUNT = FQBI_VAL_PREGIONS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        mux_mode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  //============================================================================
  // Burst field byte: code low, reserved bits zero.
  function automatic logic [7:0] burst_byte(input logic [2:0] code);
    burst_byte = {5'h00, code};
  endfunction

  // Table lookup by word index; hit reports a mapped location.
  function automatic logic [8:0] lookup(input logic [11:0] idx,
                                        input logic       mux);
    case (idx)
      FQBI_IDX_GRP_LO:   lookup = {1'b1, FQBI_VAL_GRP_LO};
      FQBI_IDX_GRP_HI:   lookup = {1'b1, FQBI_VAL_GRP_HI};
      FQBI_IDX_BYTES:    lookup = {1'b1, FQBI_VAL_BYTES};
      FQBI_IDX_PAGE:     lookup = {1'b1, mux ? FQBI_VAL_PAGE_MUX
                                             : FQBI_VAL_PAGE_NMUX};
      FQBI_IDX_BCOUNT:   lookup = {1'b1, FQBI_VAL_BCOUNT};
      FQBI_IDX_BCFG1:    lookup = {1'b1, burst_byte(FQBI_CODE_8W)};
      FQBI_IDX_BCFG2:    lookup = {1'b1, burst_byte(FQBI_CODE_16W)};
      FQBI_IDX_BCFG3:    lookup = {1'b1, burst_byte(FQBI_CODE_CONT)};
      FQBI_IDX_PREGIONS: lookup = {1'b1, REGION_COUNT};
      default:           lookup = 9'h000;
    endcase
  endfunction

  fqbi_resp_s resp_reg;
  fqbi_resp_s resp_next;
  logic       hit_reg;
  logic       hit_next;
  logic [8:0] look;
  logic       setup;

  //============================================================================
  // Decode in the setup cycle; answer registered for the access cycle.
  assign setup = psel && !penable;
  assign look  = lookup(paddr[13:2], mux_mode);

  always_comb begin
    resp_next = resp_reg;
    hit_next  = hit_reg;
    if (setup) begin
      hit_next = 1'b1;
      resp_next.slverr = pwrite || !look[8] || (paddr[1:0] != 2'h0);
      resp_next.rdata  = (pwrite || !look[8]) ? 32'h0000_0000
                         : {24'h00_0000, look[7:0]};
    end else if (psel && penable) begin
      hit_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_reg <= '0;
      hit_reg  <= 1'b0;
    end else if (clk_en) begin
      resp_reg <= resp_next;
      hit_reg  <= hit_next;
    end
  end

  // Ready in the first cycle of the access phase if clk_en was high in the setup cycle and is high then; data hold in flip-flops.
  assign pready  = psel && penable && hit_reg && clk_en;
  assign prdata  = resp_reg.rdata;
  assign pslverr = pready && resp_reg.slverr;

  //============================================================================
  sequence s_read_page;
    psel && !penable && !pwrite && paddr == {FQBI_IDX_PAGE, 2'b00};
  endsequence

  AST_PAGE_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_page ##1 (clk_en && pready) |->
      prdata == (mux_mode ? 32'h0 : 32'h5))
    else $error("page capability byte wrong");

  AST_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h0)
    else $error("upper data lines not zero");

  AST_BCOUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && clk_en && !pwrite && paddr == {FQBI_IDX_BCOUNT, 2'b00})
      ##1 pready |-> prdata == 32'h3)
    else $error("burst count wrong");

  AST_BCFG: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && clk_en && !pwrite && paddr == {FQBI_IDX_BCFG3, 2'b00})
      ##1 pready |-> prdata == 32'h7)
    else $error("continuous burst code wrong");

  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && clk_en && paddr[13:4] == 10'h04a) ##1 pready
      |-> prdata[7:3] == 5'h0 || paddr[13:2] > 12'h12b)
    else $error("reserved burst bits set");

  AST_OTP_LO: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && clk_en && !pwrite && paddr == {FQBI_IDX_GRP_LO, 2'b00})
      ##1 pready |-> prdata == 32'h10 && !pslverr)
    else $error("otp group count wrong");

  AST_ANSWER_TIME: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && clk_en) ##1 (psel && penable && clk_en) |-> pready)
    else $error("no answer in access cycle");

  AST_REGIONS: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && clk_en && !pwrite && paddr == {FQBI_IDX_PREGIONS, 2'b00})
      ##1 pready |-> prdata[7:0] == REGION_COUNT)
    else $error("region count wrong");

endmodule

`default_nettype wire

/* tb/fqbi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Host controller that issues query reads over APB.
module fqbi_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [13:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // The bus rests idle until the first transfer.
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // One transfer: setup, then access held until pready is seen high.
  task automatic xfer(input logic wr, input logic [13:0] a,
                      output logic [31:0] d, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= 32'h0000_00ff;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/test_flash_query_burst_otp_info.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// Reads the whole query table and checks refused accesses.
module test_flash_query_burst_otp_info;
  logic        pclk, presetn, mux_mode, psel, penable, pwrite;
  logic        pready, pslverr, er;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, checks;
  logic [7:0]  exp_tab [9] = '{8'h10, 8'h00, 8'h04, 8'h05, 8'h03,
                               8'h02, 8'h03, 8'h07, 8'h00};

  fqbi_query_table #(.REGION_COUNT(8'h00)) uut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .mux_mode(mux_mode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  fqbi_host host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

  // Clock of 25 ns period.
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence of reads and refused accesses.
  initial begin
    presetn  = 1'b0;
    mux_mode = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      host.xfer(1'b0, 14'h490 + 14'(4 * i), rd, er);
      chk("query word", rd, {24'h0, exp_tab[i]});
      chk("query err", {31'h0, er}, 32'h0);
    end
    mux_mode <= 1'b1;
    host.xfer(1'b0, 14'h49c, rd, er);
    chk("page mux", rd, 32'h0);
    host.xfer(1'b1, 14'h490, rd, er);
    chk("write err", {31'h0, er}, 32'h1);
    host.xfer(1'b0, 14'h490, rd, er);
    chk("after write", rd, 32'h10);
    host.xfer(1'b0, 14'h4b4, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h1);
    test_done();
  end

  // Watchdog far beyond the few dozen cycles the tests need.
  initial begin
    repeat (2000) @(posedge pclk);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
